// ==== load_scoreboard.sv ====
`timescale 1ns/100ps
module load_scoreboard
    import regfile_pkg::*;
(
    input wire logic clock_i, // core clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic alloc_i, // load accepted this cycle
    input wire logic [4:0] alloc_dest_i, // its destination register
    input wire logic free_i, // load data returns this cycle
    input wire logic [1:0] free_tag_i, // slot of the returning load
    output logic [31:0] pending_o, // one pending flag per register
    output logic full_o, // all slots busy
    output logic any_o, // some load outstanding
    output logic [1:0] free_tag_o, // lowest free slot
    output logic [2:0][4:0] slot_dest_o // destination held by each slot
);
    typedef struct packed {
        logic [2:0] valid;
        logic [2:0][4:0] dest;
    } sb_t;
    sb_t st_reg, st_next;

    always_comb begin
        st_next = st_reg;
        // clear first so a slot freed and refilled in one cycle keeps the new load
        if (free_i) begin
            st_next.valid[free_tag_i] = 1'b0;
        end
        if (alloc_i) begin
            st_next.valid[free_tag_o] = 1'b1;
            st_next.dest[free_tag_o] = alloc_dest_i;
        end
    end

    always_comb begin
        pending_o = '0;
        free_tag_o = 2'h0;
        for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
            if (st_reg.valid[i]) begin
                pending_o[st_reg.dest[i]] = 1'b1;
            end else begin
                free_tag_o = 2'(i);
            end
        end
    end

    assign full_o = &st_reg.valid;
    assign any_o = |st_reg.valid;
    assign slot_dest_o = st_reg.dest;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    a_alloc_free_slot: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        alloc_i |-> !full_o) else $error("load slot taken while all slots busy");
endmodule

// ==== regfile_pkg.sv ====
package regfile_pkg;
    localparam int WORD_W = 32;
    localparam int EXT_W = 80;
    localparam int SEL_W = 5;
    localparam int NUM_GLOBAL = 16;
    localparam int NUM_LOCAL = 16;
    localparam int NUM_EXT = 4;
    localparam int NUM_FRAMES = 4;
    localparam int NUM_SLOTS = 3;
    localparam logic [3:0] STACK_PTR_INDEX = 4'hf;
    localparam logic [3:0] LAST_WORD = 4'hf;
    localparam logic [4:0] FILL_WORDS = 5'h10;
    localparam logic [31:0] FRAME_BYTES = 32'h40;
    localparam logic [2:0] CNT_RESET = 3'h1;
    localparam logic [2:0] CNT_FULL = 3'h4;
    localparam logic [1:0] CUR_RESET = 2'h0;
    typedef enum logic [1:0] {
        OP_ALU = 2'h0,
        OP_LOAD = 2'h1,
        OP_CALL = 2'h2,
        OP_RET = 2'h3
    } op_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SPILL = 3'b010,
        ST_FILL = 3'b100
    } state_t;
endpackage

// ==== register_file_core.sv ====
`timescale 1ns/100ps
module register_file_core
    import regfile_pkg::*;
(
    input wire logic clock_i, // core clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic issue_valid_i, // decoder offers an instruction
    input wire logic [1:0] issue_op_i, // op_t code
    input wire logic [4:0] src_a_i, // operand a select
    input wire logic [4:0] src_b_i, // operand b select
    input wire logic [4:0] dest_i, // load destination select
    input wire logic wb_valid_i, // execution result write
    input wire logic [4:0] wb_dest_i, // result destination
    input wire logic [31:0] wb_data_i, // result value
    input wire logic ld_done_i, // load data returns
    input wire logic [1:0] ld_tag_i, // slot of returning load
    input wire logic [31:0] ld_data_i, // load data
    input wire logic ext_we_i, // extended real write
    input wire logic [1:0] ext_sel_i, // extended real select
    input wire logic [79:0] ext_wdata_i, // extended real write data
    input wire logic fill_valid_i, // stack word returns
    input wire logic [31:0] fill_data_i, // stack word data
    output logic issue_ack_o, // instruction taken last cycle
    output logic [1:0] load_tag_o, // slot given to an accepted load
    output logic [31:0] rd_a_o, // operand a
    output logic [31:0] rd_b_o, // operand b
    output logic [79:0] ext_rd_o, // extended real read data
    output logic spill_we_o, // stack word write
    output logic [31:0] spill_addr_o, // stack write address
    output logic [31:0] spill_data_o, // stack write data
    output logic fill_req_o, // stack word read request
    output logic [31:0] fill_addr_o // stack read address
);
    typedef struct packed {
        state_t st;
        logic ack;
        logic [1:0] tag;
        logic [31:0] rd_a;
        logic [31:0] rd_b;
        logic [79:0] ext_rd;
        logic spill_we;
        logic [31:0] spill_addr;
        logic [31:0] spill_data;
        logic fill_req;
        logic [31:0] fill_addr;
        logic [NUM_GLOBAL-1:0][31:0] glob;
        logic [NUM_EXT-1:0][79:0] ext;
        logic [NUM_FRAMES-1:0][NUM_LOCAL-1:0][31:0] frame;
        logic [1:0] cur;
        logic [2:0] cnt;
        logic [15:0] spilled;
        logic [3:0] widx;
        logic [4:0] rq;
        logic [3:0] rsp;
    } core_t;
    core_t s_reg, s_next;

    logic [31:0] pending;
    logic sb_full;
    logic sb_any;
    logic [1:0] sb_free_tag;
    logic [2:0][4:0] slot_dest;
    logic [4:0] ld_dest;
    logic refs_pending;
    logic ok;
    logic acc;
    logic [1:0] oldest;

    // bit 4 picks the global word bank, else the current local frame
    function automatic logic [31:0] read_word(input core_t s, input logic [4:0] sel,
                                               input logic wv, input logic [4:0] wd,
                                               input logic [31:0] wdat,
                                               input logic lv, input logic [4:0] ld,
                                               input logic [31:0] ldat);
        logic [31:0] v;
        v = sel[4] ? s.glob[sel[3:0]] : s.frame[s.cur][sel[3:0]];
        if (lv && ld == sel) begin
            v = ldat;
        end
        if (wv && wd == sel) begin
            v = wdat;
        end
        return v;
    endfunction

    // stack words sit four bytes apart above the stack pointer
    function automatic logic [31:0] stack_addr(input logic [31:0] base, input logic [4:0] idx);
        return base + {25'h0, idx, 2'h0};
    endfunction

    load_scoreboard load_scoreboard_inst (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .alloc_i(acc && issue_op_i == OP_LOAD),
        .alloc_dest_i(dest_i),
        .free_i(ld_done_i),
        .free_tag_i(ld_tag_i),
        .pending_o(pending),
        .full_o(sb_full),
        .any_o(sb_any),
        .free_tag_o(sb_free_tag),
        .slot_dest_o(slot_dest)
    );

    assign ld_dest = slot_dest[ld_tag_i];
    assign oldest = s_reg.cur + 2'h1;

    always_comb begin
        refs_pending = pending[src_a_i] || pending[src_b_i];
        unique case (op_t'(issue_op_i))
            OP_ALU: ok = !refs_pending;
            OP_LOAD: ok = !refs_pending && !pending[dest_i] && !sb_full;
            OP_CALL: ok = !sb_any;
            OP_RET: ok = !sb_any;
        endcase
        // the cycle after a take is a bubble so a held request is not taken twice
        acc = issue_valid_i && !s_reg.ack && s_reg.st == ST_IDLE && ok;
    end

    always_comb begin
        s_next = s_reg;
        s_next.ack = acc;
        s_next.spill_we = 1'b0;
        s_next.fill_req = 1'b0;
        s_next.ext_rd = s_reg.ext[ext_sel_i];
        if (acc) begin
            s_next.rd_a = read_word(s_reg, src_a_i, wb_valid_i, wb_dest_i, wb_data_i,
                                    ld_done_i, ld_dest, ld_data_i);
            s_next.rd_b = read_word(s_reg, src_b_i, wb_valid_i, wb_dest_i, wb_data_i,
                                    ld_done_i, ld_dest, ld_data_i);
            s_next.tag = sb_free_tag;
        end
        if (ld_done_i) begin
            if (ld_dest[4]) begin
                s_next.glob[ld_dest[3:0]] = ld_data_i;
            end else begin
                s_next.frame[s_reg.cur][ld_dest[3:0]] = ld_data_i;
            end
        end
        if (wb_valid_i) begin
            if (wb_dest_i[4]) begin
                s_next.glob[wb_dest_i[3:0]] = wb_data_i;
            end else begin
                s_next.frame[s_reg.cur][wb_dest_i[3:0]] = wb_data_i;
            end
        end
        if (ext_we_i) begin
            s_next.ext[ext_sel_i] = ext_wdata_i;
        end
        unique case (s_reg.st)
            ST_IDLE: begin
                if (acc && issue_op_i == OP_CALL) begin
                    if (s_reg.cnt == CNT_FULL) begin
                        s_next.st = ST_SPILL;
                        s_next.widx = 4'h0;
                    end else begin
                        s_next.cur = s_reg.cur + 2'h1;
                        s_next.cnt = s_reg.cnt + 3'h1;
                        s_next.frame[s_reg.cur + 2'h1] = '0;
                    end
                end else if (acc && issue_op_i == OP_RET) begin
                    if (s_reg.cnt != CNT_RESET) begin
                        s_next.cur = s_reg.cur - 2'h1;
                        s_next.cnt = s_reg.cnt - 3'h1;
                    end else if (s_reg.spilled != 16'h0) begin
                        s_next.st = ST_FILL;
                        s_next.cur = s_reg.cur - 2'h1;
                        s_next.glob[STACK_PTR_INDEX] =
                            s_reg.glob[STACK_PTR_INDEX] - FRAME_BYTES;
                        s_next.rq = 5'h0;
                        s_next.rsp = 4'h0;
                    end
                end
            end
            ST_SPILL: begin
                s_next.spill_we = 1'b1;
                s_next.spill_addr = stack_addr(s_reg.glob[STACK_PTR_INDEX],
                                               {1'b0, s_reg.widx});
                s_next.spill_data = s_reg.frame[oldest][s_reg.widx];
                s_next.widx = s_reg.widx + 4'h1;
                if (s_reg.widx == LAST_WORD) begin
                    // the spilled slot becomes the callee's fresh frame
                    s_next.st = ST_IDLE;
                    s_next.glob[STACK_PTR_INDEX] = s_reg.glob[STACK_PTR_INDEX] + FRAME_BYTES;
                    s_next.spilled = s_reg.spilled + 16'h1;
                    s_next.cur = oldest;
                    s_next.frame[oldest] = '0;
                end
            end
            ST_FILL: begin
                if (s_reg.rq != FILL_WORDS) begin
                    s_next.fill_req = 1'b1;
                    s_next.fill_addr = stack_addr(s_reg.glob[STACK_PTR_INDEX], s_reg.rq);
                    s_next.rq = s_reg.rq + 5'h1;
                end
                if (fill_valid_i) begin
                    s_next.frame[s_reg.cur][s_reg.rsp] = fill_data_i;
                    s_next.rsp = s_reg.rsp + 4'h1;
                    if (s_reg.rsp == LAST_WORD) begin
                        s_next.st = ST_IDLE;
                        s_next.spilled = s_reg.spilled - 16'h1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg <= '0;
            s_reg.st <= ST_IDLE;
            s_reg.cnt <= CNT_RESET;
            s_reg.cur <= CUR_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign issue_ack_o = s_reg.ack;
    assign load_tag_o = s_reg.tag;
    assign rd_a_o = s_reg.rd_a;
    assign rd_b_o = s_reg.rd_b;
    assign ext_rd_o = s_reg.ext_rd;
    assign spill_we_o = s_reg.spill_we;
    assign spill_addr_o = s_reg.spill_addr;
    assign spill_data_o = s_reg.spill_data;
    assign fill_req_o = s_reg.fill_req;
    assign fill_addr_o = s_reg.fill_addr;

    default clocking dc @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    a_pending_stalls: assert property (
        issue_valid_i && !s_reg.ack && refs_pending |-> ##1 !issue_ack_o)
        else $error("instruction taken while an operand was pending");
    a_load_sets_flag: assert property (
        acc && issue_op_i == OP_LOAD |=> pending[$past(dest_i)])
        else $error("load destination not marked pending");
    a_done_clears: assert property (
        ld_done_i |=> !pending[$past(ld_dest)])
        else $error("pending flag survived load return");
    a_slot_limit: assert property (
        sb_full |-> $countones(pending) == NUM_SLOTS) else $error("three loads lack three flags");
    a_full_load_stall: assert property (
        sb_full && issue_valid_i && issue_op_i == OP_LOAD |=> !issue_ack_o)
        else $error("fourth load taken");
    a_unrelated_issue: assert property (
        issue_valid_i && s_reg.st == ST_IDLE && !s_reg.ack && issue_op_i == OP_ALU
        && !refs_pending |=> issue_ack_o) else $error("independent op stalled by load");
    a_spill_burst: assert property (
        acc && issue_op_i == OP_CALL && s_reg.cnt == CNT_FULL |-> ##2 spill_we_o [*8])
        else $error("full frame cache did not spill");
    a_frame_count: assert property (
        s_reg.cnt >= CNT_RESET && s_reg.cnt <= CNT_FULL) else $error("frame count out of range");
    a_globals_kept: assert property (
        acc && issue_op_i == OP_CALL && !wb_valid_i && !ld_done_i && !ext_we_i
        |=> $stable(s_reg.glob) && $stable(s_reg.ext)) else $error("call disturbed globals");
    a_bypass_fwd: assert property (
        acc && wb_valid_i && wb_dest_i == src_a_i |=> rd_a_o == $past(wb_data_i))
        else $error("result not forwarded to operand");

    c_three_loads: cover property (sb_full);
    c_spill: cover property (spill_we_o);
    c_fill: cover property (s_reg.st == ST_FILL ##1 fill_valid_i);
    c_bypass: cover property (acc && wb_valid_i && wb_dest_i == src_b_i);
endmodule

// ==== register_file_frame_cache_scoreboard_tb_top.sv ====
`timescale 1ns/100ps
module register_file_frame_cache_scoreboard_tb_top;
    import regfile_pkg::*;
    logic clock_i = 1'b0, rst_n_i = 1'b0, slow_i = 1'b0;
    logic issue_valid_i = 1'b0, wb_valid_i = 1'b0, ld_done_i = 1'b0, ext_we_i = 1'b0;
    logic [1:0] issue_op_i = 2'h0, ld_tag_i = 2'h0, ext_sel_i = 2'h0;
    logic [4:0] src_a_i = 5'h0, src_b_i = 5'h0, dest_i = 5'h0, wb_dest_i = 5'h0;
    logic [31:0] wb_data_i = 32'h0, ld_data_i = 32'h0;
    logic [79:0] ext_wdata_i = 80'h0;
    logic fill_valid_i, issue_ack_o, spill_we_o, fill_req_o;
    logic [31:0] fill_data_i, rd_a_o, rd_b_o, spill_addr_o, spill_data_o, fill_addr_o;
    logic [1:0] load_tag_o;
    logic [79:0] ext_rd_o;
    int n_mismatch = 0, cmp_count = 0;
    register_file_core register_file_core_inst (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .issue_valid_i(issue_valid_i),
        .issue_op_i(issue_op_i), .src_a_i(src_a_i), .src_b_i(src_b_i), .dest_i(dest_i),
        .wb_valid_i(wb_valid_i), .wb_dest_i(wb_dest_i), .wb_data_i(wb_data_i),
        .ld_done_i(ld_done_i), .ld_tag_i(ld_tag_i), .ld_data_i(ld_data_i),
        .ext_we_i(ext_we_i), .ext_sel_i(ext_sel_i), .ext_wdata_i(ext_wdata_i),
        .fill_valid_i(fill_valid_i), .fill_data_i(fill_data_i), .issue_ack_o(issue_ack_o),
        .load_tag_o(load_tag_o), .rd_a_o(rd_a_o), .rd_b_o(rd_b_o), .ext_rd_o(ext_rd_o),
        .spill_we_o(spill_we_o), .spill_addr_o(spill_addr_o), .spill_data_o(spill_data_o),
        .fill_req_o(fill_req_o), .fill_addr_o(fill_addr_o));
    stack_memory_model stack_memory_model_inst (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .slow_i(slow_i), .spill_we_i(spill_we_o),
        .spill_addr_i(spill_addr_o), .spill_data_i(spill_data_o), .fill_req_i(fill_req_o),
        .fill_addr_i(fill_addr_o), .fill_valid_o(fill_valid_i), .fill_data_o(fill_data_i));
    always #2.5 clock_i = ~clock_i;
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic drive(input op_t op, input logic [4:0] a, input logic [4:0] b,
                         input logic [4:0] d);
        @(negedge clock_i);
        issue_valid_i = 1'b1;
        issue_op_i = op;
        src_a_i = a;
        src_b_i = b;
        dest_i = d;
    endtask
    // request stays up until ack is seen; a refused one is left standing
    task automatic wait_ack(input int lim, output bit got);
        got = (issue_ack_o === 1'b1);
        for (int i = 0; i < lim && !got; i++) begin
            @(posedge clock_i);
            #1;
            got = (issue_ack_o === 1'b1);
        end
        if (got) begin
            @(negedge clock_i);
            issue_valid_i = 1'b0;
        end
    endtask
    task automatic iss(input op_t op, input logic [4:0] a, input logic [4:0] b,
                       input logic [4:0] d);
        bit got;
        drive(op, a, b, d);
        wait_ack(100, got);
        chk(got, 1'b1);
    endtask
    task automatic wb(input logic [4:0] d, input logic [31:0] v);
        @(negedge clock_i);
        wb_valid_i = 1'b1;
        wb_dest_i = d;
        wb_data_i = v;
        @(negedge clock_i);
        wb_valid_i = 1'b0;
    endtask
    task automatic ld_ret(input logic [1:0] tg, input logic [31:0] v);
        @(negedge clock_i);
        ld_done_i = 1'b1;
        ld_tag_i = tg;
        ld_data_i = v;
        @(negedge clock_i);
        ld_done_i = 1'b0;
    endtask
    task automatic ext_chk(input logic [1:0] s);
        @(negedge clock_i);
        ext_sel_i = s;
        @(posedge clock_i);
        #1;
        chk(ext_rd_o, 80'h1234_5678_9abc_def0_0000 + 80'(s));
    endtask
    task automatic t_regs();
        bit got;
        for (int i = 0; i < 16; i++) begin
            wb({1'b1, 4'(i)}, 32'h2000 + 32'(i * 16));
            wb({1'b0, 4'(i)}, 32'h100 + 32'(i));
        end
        for (int i = 0; i < 16; i++) begin
            iss(OP_ALU, {1'b1, 4'(i)}, {1'b0, 4'(i)}, 5'h0);
            chk(rd_a_o, 32'h2000 + 32'(i * 16));
            chk(rd_b_o, 32'h100 + 32'(i));
        end
        for (int j = 0; j < 4; j++) begin
            @(negedge clock_i);
            ext_we_i = 1'b1;
            ext_sel_i = 2'(j);
            ext_wdata_i = 80'h1234_5678_9abc_def0_0000 + 80'(j);
        end
        @(negedge clock_i);
        ext_we_i = 1'b0;
        for (int j = 0; j < 4; j++) ext_chk(2'(j));
        drive(OP_ALU, 5'h07, 5'h10, 5'h0);
        wb_valid_i = 1'b1;
        wb_dest_i = 5'h07;
        wb_data_i = 32'h77;
        wait_ack(4, got);
        wb_valid_i = 1'b0;
        chk(rd_a_o, 32'h77);
    endtask
    task automatic t_loads();
        logic [1:0] tg [4];
        bit got;
        for (int i = 0; i < 3; i++) begin
            iss(OP_LOAD, 5'h10, 5'h11, 5'(i + 1));
            tg[i] = load_tag_o;
        end
        chk({tg[0] == tg[1], tg[0] == tg[2], tg[1] == tg[2]}, 80'h0);
        drive(OP_LOAD, 5'h10, 5'h11, 5'h04);
        wait_ack(8, got);
        chk(got, 1'b0);
        ld_ret(tg[0], 32'h11);
        wait_ack(8, got);
        chk(got, 1'b1);
        tg[3] = load_tag_o;
        chk(tg[3], tg[0]);
        iss(OP_ALU, 5'h12, 5'h13, 5'h0);
        chk(rd_a_o, 32'h2020);
        chk(rd_b_o, 32'h2030);
        drive(OP_ALU, 5'h02, 5'h10, 5'h0);
        wait_ack(8, got);
        chk(got, 1'b0);
        ld_ret(tg[1], 32'h22);
        wait_ack(8, got);
        chk(got, 1'b1);
        chk(rd_a_o, 32'h22);
        ld_ret(tg[2], 32'h33);
        ld_ret(tg[3], 32'h44);
        iss(OP_ALU, 5'h01, 5'h04, 5'h0);
        chk(rd_a_o, 32'h11);
        chk(rd_b_o, 32'h44);
    endtask
    task automatic t_frames();
        for (int i = 0; i < 16; i++) wb({1'b0, 4'(i)}, 32'h500 + 32'(i));
        for (int k = 1; k < 4; k++) begin
            iss(OP_CALL, 5'h0, 5'h0, 5'h0);
            iss(OP_ALU, 5'h00, 5'h1f, 5'h0);
            chk(rd_a_o, 32'h0);
            chk(rd_b_o, 32'h20f0);
            wb(5'h00, 32'(k));
        end
        chk(32'(stack_memory_model_inst.n_wr), 32'h0);
        iss(OP_CALL, 5'h0, 5'h0, 5'h0);
        // spill runs a fixed 16 cycles after the ack
        repeat (20) @(negedge clock_i);
        chk(32'(stack_memory_model_inst.n_wr), 32'h10);
        for (int i = 0; i < 16; i++)
            chk(stack_memory_model_inst.mem[32'h20f0 + 32'(i * 4)], 32'h500 + 32'(i));
        iss(OP_ALU, 5'h1f, 5'h00, 5'h0);
        chk(rd_a_o, 32'h2130);
        chk(rd_b_o, 32'h0);
        for (int k = 3; k > 0; k--) begin
            iss(OP_RET, 5'h0, 5'h0, 5'h0);
            iss(OP_ALU, 5'h00, 5'h10, 5'h0);
            chk(rd_a_o, 32'(k));
        end
        slow_i = 1'b1;
        iss(OP_RET, 5'h0, 5'h0, 5'h0);
        iss(OP_ALU, 5'h00, 5'h0f, 5'h0);
        chk(rd_a_o, 32'h500);
        chk(rd_b_o, 32'h50f);
        iss(OP_ALU, 5'h1f, 5'h1e, 5'h0);
        chk(rd_a_o, 32'h20f0);
        chk(rd_b_o, 32'h20e0);
        for (int j = 0; j < 4; j++) ext_chk(2'(j));
    endtask
    initial begin
        repeat (6) @(posedge clock_i);
        @(negedge clock_i);
        rst_n_i = 1'b1;
        t_regs();
        t_loads();
        t_frames();
        complete_run();
    end
    // the whole run needs about 320 cycles
    initial begin
        #100000;
        n_mismatch++;
        complete_run();
    end
endmodule

// ==== stack_memory_model.sv ====
`timescale 1ns/100ps
module stack_memory_model (
    input wire logic clock_i, // core clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic slow_i, // stretch fill latency
    input wire logic spill_we_i, // stack word write
    input wire logic [31:0] spill_addr_i, // write address
    input wire logic [31:0] spill_data_i, // write data
    input wire logic fill_req_i, // stack word read request
    input wire logic [31:0] fill_addr_i, // read address
    output logic fill_valid_o, // read word returns
    output logic [31:0] fill_data_o // read word data
);
    logic [31:0] mem [bit [31:0]];
    bit [31:0] rq [$];
    int n_wr = 0;
    int gap = 0;
    initial fill_valid_o = 1'b0;
    initial fill_data_o = 32'h0;
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rq.delete();
            gap = 0;
            fill_valid_o <= 1'b0;
        end else begin
            if (spill_we_i) begin
                mem[spill_addr_i] = spill_data_i;
                n_wr++;
            end
            if (fill_req_i)
                rq.push_back(fill_addr_i);
            if (rq.size() != 0 && gap == 0) begin
                fill_valid_o <= 1'b1;
                fill_data_o <= mem.exists(rq[0]) ? mem[rq[0]] : 32'h0;
                void'(rq.pop_front());
                gap = slow_i ? 3 : 0;
            end else begin
                fill_valid_o <= 1'b0;
                // idle data toggles so a stale word is never taken for a fresh one
                fill_data_o <= ~fill_data_o;
                if (gap != 0)
                    gap--;
            end
        end
    end
endmodule
